//--- rtl/rx_lane_map_and_fcs_status.sv
/*
  Receive status block: PCS lane to physical lane map, per-lane demux
  status, and per-cycle counts of frames ending with a wrong or an
  inverted checksum, plus an AXI4-Lite register slave.
  Assumes lane-marker detection, lock detection and FCS computation
  sit upstream on the same clock and present their results as inputs.
*/
`timescale 1ns/100ps

module rx_lane_map_and_fcs_status
  import lane_status_pkg::*;
#(
  parameter int unsigned NUM_SEGMENTS = lane_status_pkg::SEGMENTS
) (
  // Clock and reset
  input  wire logic                                 aclk,
  input  wire logic                                 aresetn,
  // Upstream lane marker and lock inputs
  input  wire lane_status_pkg::marker_type [lane_status_pkg::PCS_LANES-1:0] marker_in,
  input  wire logic [lane_status_pkg::PCS_LANES-1:0] rx_lane_marker_lock,
  // Upstream frame end checksum inputs
  input  wire lane_status_pkg::fcs_end_type [NUM_SEGMENTS-1:0] fcs_in,
  // Status outputs
  output lane_status_pkg::lane_map_type              rx_pcs_lane_physical_index,
  output logic [lane_status_pkg::PCS_LANES-1:0]      rx_lane_demux_ok,
  output logic [lane_status_pkg::COUNT_W-1:0]        rx_checksum_fail_count,
  output logic [lane_status_pkg::COUNT_W-1:0]        rx_checksum_inverted_count,
  // AXI4-Lite write channels
  input  wire logic [lane_status_pkg::ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                                 s_axi_awvalid,
  output logic                                      s_axi_awready,
  input  wire logic [lane_status_pkg::DATA_W-1:0]    s_axi_wdata,
  input  wire logic [3:0]                           s_axi_wstrb,
  input  wire logic                                 s_axi_wvalid,
  output logic                                      s_axi_wready,
  output logic [1:0]                                s_axi_bresp,
  output logic                                      s_axi_bvalid,
  input  wire logic                                 s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [lane_status_pkg::ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                                 s_axi_arvalid,
  output logic                                      s_axi_arready,
  output logic [lane_status_pkg::DATA_W-1:0]         s_axi_rdata,
  output logic [1:0]                                s_axi_rresp,
  output logic                                      s_axi_rvalid,
  input  wire logic                                 s_axi_rready
);
  import lane_status_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Every segment may end a frame in one cycle; the count must hold it
  if (NUM_SEGMENTS < 1 || NUM_SEGMENTS > (2**COUNT_W) - 1) begin : g_bad_segments
    $error("NUM_SEGMENTS does not fit the count output width");
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Saturating add of a per-cycle count to a running total
  function automatic logic [TOTAL_W-1:0] sat_add(input logic [TOTAL_W-1:0] total,
                                                 input logic [COUNT_W-1:0] inc);
    logic [TOTAL_W:0] sum;
    sum = {1'b0, total} + {{(TOTAL_W+1-COUNT_W){1'b0}}, inc};
    sat_add = sum[TOTAL_W] ? '1 : sum[TOTAL_W-1:0];
  endfunction

  // True when the address lies in the lane map window
  function automatic logic in_lane_map(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] off;
    off = addr - LANE_MAP_BASE;
    in_lane_map = (addr >= LANE_MAP_BASE) && (off[1:0] == 2'b00)
                  && (off[ADDR_W-1:2] < PCS_LANES[ADDR_W-3:0]);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  lane_map_type                 map_q, map_d;
  logic [PCS_LANES-1:0]         demux_q, demux_d;
  logic [COUNT_W-1:0]           fail_q, fail_d;
  logic [COUNT_W-1:0]           inv_q, inv_d;
  logic [TOTAL_W-1:0]           fail_tot_q, fail_tot_d;
  logic [TOTAL_W-1:0]           inv_tot_q, inv_tot_d;
  logic                         report_q, report_d;
  logic                         clear_req;

  // ----------------------------------------------------------------
  // Lane map and demux status
  // ----------------------------------------------------------------
  // A marker on physical lane p naming PCS lane v records p for v
  always_comb begin
    map_d   = map_q;
    demux_d = demux_q;
    for (int p = 0; p < PCS_LANES; p++) begin
      if (marker_in[p].hit && marker_in[p].pcs_lane < PCS_LANES[LANE_IDX_W-1:0]) begin
        map_d[marker_in[p].pcs_lane] = p[LANE_IDX_W-1:0];
        demux_d[marker_in[p].pcs_lane] = 1'b1;
      end
    end
    // Demux only stands while that lane keeps its marker lock
    demux_d = demux_d & rx_lane_marker_lock;
  end

  // ----------------------------------------------------------------
  // Checksum classification
  // ----------------------------------------------------------------
  // Each frame end is good, inverted (stomped) or wrong
  always_comb begin
    fail_d = '0;
    inv_d  = '0;
    for (int s = 0; s < NUM_SEGMENTS; s++) begin
      if (fcs_in[s].frame_end && report_q) begin
        if (fcs_in[s].fcs_rx == ~fcs_in[s].fcs_calc) begin
          inv_d = inv_d + COUNT_W'(1);
        end else if (fcs_in[s].fcs_rx != fcs_in[s].fcs_calc) begin
          fail_d = fail_d + COUNT_W'(1);
        end
      end
    end
    // Counts are rebuilt each cycle, so they last one cycle only
  end

  // Running totals; an event in the clearing cycle is kept
  always_comb begin
    fail_tot_d = sat_add(clear_req ? '0 : fail_tot_q, fail_q);
    inv_tot_d  = sat_add(clear_req ? '0 : inv_tot_q, inv_q);
  end

  // Status registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      map_q      <= '0;
      demux_q    <= '0;
      fail_q     <= '0;
      inv_q      <= '0;
      fail_tot_q <= '0;
      inv_tot_q  <= '0;
    end else begin
      map_q      <= map_d;
      demux_q    <= demux_d;
      fail_q     <= fail_d;
      inv_q      <= inv_d;
      fail_tot_q <= fail_tot_d;
      inv_tot_q  <= inv_tot_d;
    end
  end

  assign rx_pcs_lane_physical_index = map_q;
  assign rx_lane_demux_ok           = demux_q;
  assign rx_checksum_fail_count     = fail_q;
  assign rx_checksum_inverted_count = inv_q;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic                 aw_held_q, aw_held_d;
  logic [ADDR_W-1:0]    aw_addr_q, aw_addr_d;
  logic                 w_held_q, w_held_d;
  logic [DATA_W-1:0]    w_data_q, w_data_d;
  logic [3:0]           w_strb_q, w_strb_d;
  logic                 awready_q, awready_d;
  logic                 wready_q, wready_d;
  logic                 bvalid_q, bvalid_d;
  logic [1:0]           bresp_q, bresp_d;
  logic                 arready_q, arready_d;
  logic                 rvalid_q, rvalid_d;
  logic [1:0]           rresp_q, rresp_d;
  logic [DATA_W-1:0]    rdata_q, rdata_d;
  logic                 do_write;
  logic [ADDR_W-1:0]    lane_off;

  // Write path: address and data held apart, write once both are in
  always_comb begin
    aw_held_d = aw_held_q;
    aw_addr_d = aw_addr_q;
    w_held_d  = w_held_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    report_d  = report_q;
    clear_req = 1'b0;
    do_write  = aw_held_q && w_held_q && !bvalid_q;
    if (s_axi_awvalid && awready_q) begin
      aw_held_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_held_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = RESP_SLVERR;
      if (aw_addr_q == CTRL_ADDR) begin
        bresp_d = RESP_OKAY;
        if (w_strb_q[0]) begin
          report_d  = w_data_q[CTRL_REPORT_BIT];
          clear_req = w_data_q[CTRL_CLEAR_BIT];
        end
      end
    end
    awready_d = !aw_held_d && !bvalid_d;
    wready_d  = !w_held_d && !bvalid_d;
  end

  // Read path: one read at a time, answered the cycle after acceptance
  always_comb begin
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    lane_off  = s_axi_araddr - LANE_MAP_BASE;
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      rdata_d  = '0;
      case (s_axi_araddr)
        CTRL_ADDR:     rdata_d[CTRL_REPORT_BIT] = report_q;
        LOCK_ADDR:     rdata_d[PCS_LANES-1:0] = rx_lane_marker_lock;
        DEMUX_ADDR:    rdata_d[PCS_LANES-1:0] = demux_q;
        FAIL_TOT_ADDR: rdata_d = fail_tot_q;
        INV_TOT_ADDR:  rdata_d = inv_tot_q;
        default: begin
          if (in_lane_map(s_axi_araddr)) begin
            rdata_d[LANE_IDX_W-1:0] = map_q[lane_off[ADDR_W-1:2]];
          end else begin
            rresp_d = RESP_SLVERR;
          end
        end
      endcase
    end
    arready_d = !rvalid_d;
  end

  // Bus registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
      w_held_q  <= 1'b0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= '0;
      report_q  <= CTRL_REPORT_RST;
    end else begin
      aw_held_q <= aw_held_d;
      aw_addr_q <= aw_addr_d;
      w_held_q  <= w_held_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
      report_q  <= report_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

endmodule

//--- rtl/lane_status_pkg.sv
/*
  Shared constants and carrier types for the receive lane map and
  checksum status block.
  Assumes a 32-bit AXI4-Lite register bus and same-clock upstream logic.
*/
package lane_status_pkg;

  // ----------------------------------------------------------------
  // Lane and count geometry
  // ----------------------------------------------------------------
  localparam int unsigned PCS_LANES   = 20;
  localparam int unsigned LANE_IDX_W  = 5;
  localparam int unsigned COUNT_W     = 4;
  localparam int unsigned SEGMENTS    = 4;
  localparam int unsigned FCS_W       = 32;
  localparam int unsigned TOTAL_W     = 32;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned  ADDR_W          = 8;
  localparam int unsigned  DATA_W          = 32;
  localparam logic [7:0]   CTRL_ADDR       = 8'h00;
  localparam logic [7:0]   LOCK_ADDR       = 8'h04;
  localparam logic [7:0]   DEMUX_ADDR      = 8'h08;
  localparam logic [7:0]   FAIL_TOT_ADDR   = 8'h0c;
  localparam logic [7:0]   INV_TOT_ADDR    = 8'h10;
  localparam logic [7:0]   LANE_MAP_BASE   = 8'h40;
  localparam int unsigned  CTRL_REPORT_BIT = 0;
  localparam int unsigned  CTRL_CLEAR_BIT  = 1;
  localparam logic         CTRL_REPORT_RST = 1'b1;
  localparam logic [1:0]   RESP_OKAY       = 2'b00;
  localparam logic [1:0]   RESP_SLVERR     = 2'b10;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  // Lane marker seen on one physical lane, naming its PCS lane
  typedef struct packed {
    logic                  hit;
    logic [LANE_IDX_W-1:0] pcs_lane;
  } marker_type;

  // Frame end on one datapath segment with received and computed FCS
  typedef struct packed {
    logic             frame_end;
    logic [FCS_W-1:0] fcs_rx;
    logic [FCS_W-1:0] fcs_calc;
  } fcs_end_type;

  typedef logic [PCS_LANES-1:0][LANE_IDX_W-1:0] lane_map_type;

endpackage

//--- dv/link_partner_model.sv
/*
  Remote link partner model: lane markers and frame ends with checksums.
  Assumes the bench calls its tasks and that upstream is on aclk.
*/
`timescale 1ns/100ps
module link_partner_model #(
  parameter int unsigned NUM_SEGMENTS = lane_status_pkg::SEGMENTS
) (
  // Clock
  input  wire logic                                                 aclk,
  // Link side towards the block
  output lane_status_pkg::marker_type [lane_status_pkg::PCS_LANES-1:0] marker_in,
  output lane_status_pkg::fcs_end_type [NUM_SEGMENTS-1:0]             fcs_in
);
  import lane_status_pkg::*;

  // Quiet link at time zero
  initial begin
    marker_in = '0;
    fcs_in = '0;
  end

  // No markers or frame ends; payload changes every cycle so stale values never match
  task automatic idle();
    @(posedge aclk);
    for (int p = 0; p < PCS_LANES; p++) marker_in[p] <= {1'b0, LANE_IDX_W'($urandom)};
    for (int s = 0; s < NUM_SEGMENTS; s++) fcs_in[s] <= {1'b0, $urandom, $urandom};
  endtask

  // One marker on every physical lane p, naming PCS lane perm[p]
  task automatic markers(input lane_map_type perm);
    @(posedge aclk);
    for (int p = 0; p < PCS_LANES; p++) marker_in[p] <= {1'b1, perm[p]};
  endtask

  // Kind per segment: 0 none, 1 good, 2 wrong, 3 inverted checksum
  task automatic frames(input logic [NUM_SEGMENTS-1:0][1:0] kind);
    logic [FCS_W-1:0] c;
    @(posedge aclk);
    for (int s = 0; s < NUM_SEGMENTS; s++) begin
      c = $urandom;
      case (kind[s])
        2'd1: fcs_in[s] <= {1'b1, c, c};
        2'd2: fcs_in[s] <= {1'b1, c ^ (32'h1 << ($urandom % 32)), c};
        2'd3: fcs_in[s] <= {1'b1, ~c, c};
        default: fcs_in[s] <= {1'b0, $urandom, c};
      endcase
    end
  endtask
endmodule

//--- dv/rx_status_checker.sv
/*
  Assertions on the lane map, demux and checksum count outputs.
  Assumes report enable is one whenever frame ends arrive.
*/
`timescale 1ns/100ps
module rx_status_checker #(
  parameter int unsigned NUM_SEGMENTS = lane_status_pkg::SEGMENTS
) (
  input wire logic                                                    aclk,
  input wire logic                                                    aresetn,
  input wire lane_status_pkg::marker_type [lane_status_pkg::PCS_LANES-1:0] marker_in,
  input wire logic [lane_status_pkg::PCS_LANES-1:0]                   rx_lane_marker_lock,
  input wire lane_status_pkg::fcs_end_type [NUM_SEGMENTS-1:0]         fcs_in,
  input wire lane_status_pkg::lane_map_type                           rx_pcs_lane_physical_index,
  input wire logic [lane_status_pkg::PCS_LANES-1:0]                   rx_lane_demux_ok,
  input wire logic [lane_status_pkg::COUNT_W-1:0]                     rx_checksum_fail_count,
  input wire logic [lane_status_pkg::COUNT_W-1:0]                     rx_checksum_inverted_count
);
  import lane_status_pkg::*;
  logic [COUNT_W-1:0]   fail_n;
  logic [COUNT_W-1:0]   inv_n;
  logic                 any_end;
  logic [PCS_LANES-1:0] hit_v;
  logic [PCS_LANES-1:0] demux_d;
  lane_map_type         exp_map;

  // Expected counts of this cycle's frame ends
  always_comb begin
    fail_n = '0;
    inv_n = '0;
    any_end = 1'b0;
    for (int s = 0; s < NUM_SEGMENTS; s++) begin
      any_end = any_end | fcs_in[s].frame_end;
      if (fcs_in[s].frame_end && fcs_in[s].fcs_rx == ~fcs_in[s].fcs_calc) inv_n = inv_n + 1'b1;
      if (fcs_in[s].frame_end && fcs_in[s].fcs_rx != fcs_in[s].fcs_calc
          && fcs_in[s].fcs_rx != ~fcs_in[s].fcs_calc) fail_n = fail_n + 1'b1;
    end
  end

  // Expected map after this cycle's markers, highest physical lane last
  always_comb begin
    exp_map = rx_pcs_lane_physical_index;
    hit_v = '0;
    for (int p = 0; p < PCS_LANES; p++) begin
      if (marker_in[p].hit && marker_in[p].pcs_lane < PCS_LANES) begin
        exp_map[marker_in[p].pcs_lane] = LANE_IDX_W'(p);
        hit_v[marker_in[p].pcs_lane] = 1'b1;
      end
    end
  end
  assign demux_d = rx_lane_marker_lock & (rx_lane_demux_ok | hit_v);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence quiet_s;
    !any_end;
  endsequence
  sequence pulse_s;
    rx_checksum_fail_count != '0 || rx_checksum_inverted_count != '0;
  endsequence

  fail_count_a: assert property ($past(aresetn) |-> rx_checksum_fail_count == $past(fail_n))
    else $error("fail count differs from wrong checksums one cycle earlier");
  inv_count_a: assert property ($past(aresetn) |-> rx_checksum_inverted_count == $past(inv_n))
    else $error("inverted count differs from inverted checksums one cycle earlier");
  counts_idle_a: assert property (quiet_s ##1 1'b1 |-> rx_checksum_fail_count == '0 && rx_checksum_inverted_count == '0)
    else $error("count nonzero after a cycle without frame ends");
  pulse_once_a: assert property (pulse_s ##0 quiet_s |=> rx_checksum_inverted_count == '0 && rx_checksum_fail_count == '0)
    else $error("count held beyond one cycle");
  lane_map_a: assert property ($past(aresetn) |-> rx_pcs_lane_physical_index == $past(exp_map))
    else $error("lane index does not follow the markers");
  map_hold_a: assert property (hit_v == '0 |=> $stable(rx_pcs_lane_physical_index))
    else $error("lane index changed without a marker");
  demux_track_a: assert property ($past(aresetn) |-> rx_lane_demux_ok == $past(demux_d))
    else $error("demux status does not follow markers and lock");
  demux_lock_a: assert property ((rx_lane_demux_ok & ~$past(rx_lane_marker_lock)) == '0)
    else $error("demux status set on a lane without lock");
endmodule

bind rx_lane_map_and_fcs_status rx_status_checker #(.NUM_SEGMENTS(NUM_SEGMENTS)) chk (
  .aclk(aclk), .aresetn(aresetn), .marker_in(marker_in),
  .rx_lane_marker_lock(rx_lane_marker_lock), .fcs_in(fcs_in),
  .rx_pcs_lane_physical_index(rx_pcs_lane_physical_index), .rx_lane_demux_ok(rx_lane_demux_ok),
  .rx_checksum_fail_count(rx_checksum_fail_count),
  .rx_checksum_inverted_count(rx_checksum_inverted_count)
);

//--- dv/rx_lane_map_and_fcs_status_tb.sv
/*
  Self-checking bench: lane map, demux, checksum counts and registers.
  Assumes the partner model drives the link inputs.
*/
`timescale 1ns/100ps
module rx_lane_map_and_fcs_status_tb;
  import lane_status_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = '0, araddr = '0, e;
  logic [31:0] wdata = '0, rdata;
  logic [1:0] bresp, rresp;
  logic [PCS_LANES-1:0] lock = '0, demux;
  logic [3:0] strb = 4'hf;
  logic [COUNT_W-1:0] fcnt, icnt;
  lane_map_type idx, perm;
  marker_type [PCS_LANES-1:0] marker_in;
  fcs_end_type [SEGMENTS-1:0] fcs_in;
  logic [SEGMENTS-1:0][1:0] kind;
  logic [7:0] exp_q[$];
  int error_cnt = 0, checks_done = 0, cyc = 0, tf = 0, ti = 0, nf, ni, j;

  rx_lane_map_and_fcs_status dut (.aclk(aclk), .aresetn(aresetn), .marker_in(marker_in),
    .rx_lane_marker_lock(lock), .fcs_in(fcs_in), .rx_pcs_lane_physical_index(idx),
    .rx_lane_demux_ok(demux), .rx_checksum_fail_count(fcnt), .rx_checksum_inverted_count(icnt),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  link_partner_model partner (.aclk(aclk), .marker_in(marker_in), .fcs_in(fcs_in));

  // Clock, hang guard and count monitor
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      end_of_test();
    end
  end
  always @(posedge aclk) begin
    if (aresetn && (fcnt !== '0 || icnt !== '0)) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
      check({fcnt, icnt}, e);
    end
  end

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Register write and read; waits on the slave's answer
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    check(bresp, r);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    check({rdata, rresp}, {d, r});
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hc703));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    lock <= '1;
    @(posedge aclk);
    #1 check({idx, demux, fcnt, icnt}, '0);
    // Random lane permutation, then one marker per physical lane
    for (int v = 0; v < PCS_LANES; v++) perm[v] = LANE_IDX_W'(v);
    for (int i = PCS_LANES - 1; i > 0; i--) begin
      j = $urandom % (i + 1);
      {perm[i], perm[j]} = {perm[j], perm[i]};
    end
    partner.markers(perm);
    partner.idle();
    #1 check(demux, {PCS_LANES{1'b1}});
    for (int p = 0; p < PCS_LANES; p++) check(idx[perm[p]], p);
    axi_rd(LANE_MAP_BASE + 8'(4 * perm[3]), 32'd3, RESP_OKAY);
    // Lock loss clears demux for that lane only
    lock[5] <= 1'b0;
    partner.markers(perm);
    partner.idle();
    #1 check(demux, 20'hfffdf);
    lock[5] <= 1'b1;
    // Back-to-back frame ends of every checksum kind
    repeat (60) begin
      nf = 0;
      ni = 0;
      for (int s = 0; s < SEGMENTS; s++) begin
        kind[s] = 2'($urandom);
        nf += (kind[s] == 2'd2);
        ni += (kind[s] == 2'd3);
      end
      tf += nf;
      ti += ni;
      if (nf + ni > 0) exp_q.push_back({4'(nf), 4'(ni)});
      partner.frames(kind);
    end
    repeat (3) partner.idle();
    check(exp_q.size(), 0);
    // Totals and refused accesses
    axi_rd(FAIL_TOT_ADDR, tf, RESP_OKAY);
    axi_rd(INV_TOT_ADDR, ti, RESP_OKAY);
    axi_rd(LOCK_ADDR, {12'h0, lock}, RESP_OKAY);
    axi_rd(8'h20, 32'h0, RESP_SLVERR);
    axi_wr(LOCK_ADDR, 32'h0, RESP_SLVERR);
    // Control write without its low byte lane has no effect
    strb <= 4'he;
    axi_wr(CTRL_ADDR, 32'h0, RESP_OKAY);
    strb <= 4'hf;
    axi_rd(CTRL_ADDR, 32'h1, RESP_OKAY);
    // Report enable off and back on, with no frame ends meanwhile
    axi_wr(CTRL_ADDR, 32'h0, RESP_OKAY);
    axi_rd(CTRL_ADDR, 32'h0, RESP_OKAY);
    axi_wr(CTRL_ADDR, 32'h3, RESP_OKAY);
    axi_rd(CTRL_ADDR, 32'h1, RESP_OKAY);
    axi_rd(FAIL_TOT_ADDR, 32'h0, RESP_OKAY);
    end_of_test();
  end
endmodule
